// ===== verilog/spdr_pkg.sv
// constants for the serial port data buffers and rate generator
package spdr_pkg;
   // register byte addresses
   localparam logic [7:0] SPDR_ADDR_RXDATA = 8'h00;
   localparam logic [7:0] SPDR_ADDR_TXDATA = 8'h04;
   localparam logic [7:0] SPDR_ADDR_DIVLO = 8'h08;
   localparam logic [7:0] SPDR_ADDR_DIVHI = 8'h0C;
   localparam logic [7:0] SPDR_ADDR_RXSTA = 8'h10;
   localparam logic [7:0] SPDR_ADDR_TXSTA = 8'h14;
   localparam logic [7:0] SPDR_ADDR_RATE = 8'h18;
   // receive status and control fields
   localparam int SPDR_RX_SPEN = 7;
   localparam int SPDR_RX_RX9 = 6;
   localparam int SPDR_RX_CREN = 4;
   localparam int SPDR_RX_FERR = 2;
   localparam int SPDR_RX_OERR = 1;
   localparam int SPDR_RX_NINTH = 0;
   localparam logic [7:0] SPDR_RX_WMASK = 8'hF8;
   // transmit status and control fields
   localparam int SPDR_TX_TX9 = 6;
   localparam int SPDR_TX_TXEN = 5;
   localparam int SPDR_TX_SYNC = 4;
   localparam int SPDR_TX_FAST_RATE_SELECT = 2;
   localparam int SPDR_TX_TRMT = 1;
   localparam logic [7:0] SPDR_TX_WMASK = 8'hFD;
   // rate control fields
   localparam int SPDR_RC_IDLE = 6;
   localparam int SPDR_RC_WIDE = 3;
   localparam logic [7:0] SPDR_RC_WMASK = 8'h08;
   // reset values
   localparam logic [7:0] SPDR_RST_BYTE = 8'h00;
   // divide factors as shifts: 64, 16 and 4
   localparam logic [2:0] SPDR_SH_64 = 3'h6;
   localparam logic [2:0] SPDR_SH_16 = 3'h4;
   localparam logic [2:0] SPDR_SH_4 = 3'h2;
   localparam logic [3:0] SPDR_BITS8 = 4'h8;
   localparam logic [3:0] SPDR_BITS9 = 4'h9;
   localparam int SPDR_PW = 23;
   localparam int SPDR_BUFW = 10;

   typedef enum logic [3:0] {
      PH_IDLE = 4'b0001,
      PH_START = 4'b0010,
      PH_DATA = 4'b0100,
      PH_STOP = 4'b1000
   } spdr_phase_t;

   typedef struct packed {
      logic [7:0] txData;
      logic txFull;
      logic [7:0] divLo;
      logic [7:0] divHi;
      logic [7:0] rxSta;
      logic [7:0] txSta;
      logic [7:0] rateCtl;
      logic ferr;
      logic oerr;
      logic [1:0][SPDR_BUFW-1:0] bufMem;
      logic bufWr;
      logic bufRd;
      logic [1:0] bufCnt;
      logic [SPDR_PW-1:0] brgCnt;
      logic [SPDR_PW-1:0] rxCnt;
      spdr_phase_t txPh;
      spdr_phase_t rxPh;
      logic [8:0] txShift;
      logic [3:0] txBits;
      logic [8:0] rxShift;
      logic [3:0] rxBits;
      logic [2:0] pinSync;
      logic rxLevel;
      logic txPin;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } spdr_state_t;
endpackage

// ===== verilog/spdr_core.sv
// serial port data buffers, rate generator and apb register file
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module spdr_core (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial line
   input wire logic rxPin,
   output logic txPin
);
   import spdr_pkg::*;

   spdr_state_t s_r;
   spdr_state_t s_nxt;

   logic wide;
   logic syncMode;
   logic [15:0] divisor;
   logic [2:0] shiftAmt;
   logic [SPDR_PW-1:0] periodLen;
   logic [SPDR_PW-1:0] periodBase;
   logic access;
   logic bitTick;
   logic [3:0] txLen;
   logic [3:0] rxLen;
   logic rxPush;
   logic [SPDR_BUFW-1:0] rxWord;
   logic bufPop;
   logic bufPush;
   logic [SPDR_BUFW-1:0] bufHead;
   logic spen;

   ////////////////////////////////////////////////////////////////
   // rate selection
   always_comb begin
      wide = s_r.rateCtl[SPDR_RC_WIDE];
      syncMode = s_r.txSta[SPDR_TX_SYNC];
      if (wide) begin
         divisor = {s_r.divHi, s_r.divLo};
      end else begin
         divisor = {8'h00, s_r.divLo};
      end
      if (syncMode) begin
         shiftAmt = SPDR_SH_4;
      end else if (s_r.txSta[SPDR_TX_FAST_RATE_SELECT]) begin
         shiftAmt = wide ? SPDR_SH_4 : SPDR_SH_16;
      end else begin
         shiftAmt = wide ? SPDR_SH_16 : SPDR_SH_64;
      end
      periodBase = {7'h00, divisor} + 23'h000001;
      // widest case 16 * 65536 still fits the counter
      periodLen = periodBase << shiftAmt;
   end

   ////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_nxt = s_r;
      spen = s_r.rxSta[SPDR_RX_SPEN];
      access = psel & penable & s_r.pready;
      bitTick = 1'b0;
      rxPush = 1'b0;
      rxWord = {SPDR_BUFW{1'b0}};
      bufPop = 1'b0;
      bufPush = 1'b0;
      bufHead = s_r.bufMem[s_r.bufRd];
      txLen = s_r.txSta[SPDR_TX_TX9] ? SPDR_BITS9 : SPDR_BITS8;
      rxLen = s_r.rxSta[SPDR_RX_RX9] ? SPDR_BITS9 : SPDR_BITS8;

      // pin synchroniser: a change counts once stages two and three agree
      s_nxt.pinSync = {s_r.pinSync[1:0], rxPin};
      if (s_r.pinSync[1] == s_r.pinSync[2]) begin
         s_nxt.rxLevel = s_r.pinSync[2];
      end

      // rate generator: one tick per bit period
      // compare is >= so a shorter period written mid-count still wraps at once
      if (s_r.brgCnt >= periodLen - 23'h000001) begin
         s_nxt.brgCnt = {SPDR_PW{1'b0}};
         bitTick = 1'b1;
      end else begin
         s_nxt.brgCnt = s_r.brgCnt + 23'h000001;
      end

      // transmitter
      unique case (s_r.txPh)
         PH_IDLE: begin
            s_nxt.txPin = 1'b1;
            if (bitTick && s_r.txFull && s_r.txSta[SPDR_TX_TXEN] && spen) begin
               s_nxt.txShift = {s_r.txSta[0], s_r.txData};
               // holding register frees as soon as the frame starts
               s_nxt.txFull = 1'b0;
               s_nxt.txBits = 4'h0;
               s_nxt.txPin = 1'b0;
               s_nxt.txPh = PH_START;
            end
         end
         PH_START: begin
            if (bitTick) begin
               s_nxt.txPin = s_r.txShift[0];
               s_nxt.txShift = {1'b0, s_r.txShift[8:1]};
               s_nxt.txBits = 4'h1;
               s_nxt.txPh = PH_DATA;
            end
         end
         PH_DATA: begin
            if (bitTick) begin
               if (s_r.txBits == txLen) begin
                  s_nxt.txPin = 1'b1;
                  s_nxt.txPh = PH_STOP;
               end else begin
                  s_nxt.txPin = s_r.txShift[0];
                  s_nxt.txShift = {1'b0, s_r.txShift[8:1]};
                  s_nxt.txBits = s_r.txBits + 4'h1;
               end
            end
         end
         PH_STOP: begin
            if (bitTick) begin
               s_nxt.txPh = PH_IDLE;
            end
         end
         default: begin
            s_nxt.txPh = PH_IDLE;
         end
      endcase

      // receiver: sample each bit at its middle
      // limitation: one sample per bit, no majority vote against line noise
      if (s_r.rxCnt != {SPDR_PW{1'b0}}) begin
         s_nxt.rxCnt = s_r.rxCnt - 23'h000001;
      end
      unique case (s_r.rxPh)
         PH_IDLE: begin
            if (!s_r.rxLevel && spen && s_r.rxSta[SPDR_RX_CREN]) begin
               s_nxt.rxCnt = periodLen >> 1;
               s_nxt.rxPh = PH_START;
            end
         end
         PH_START: begin
            if (s_r.rxCnt == {SPDR_PW{1'b0}}) begin
               s_nxt.rxCnt = periodLen - 23'h000001;
               s_nxt.rxBits = 4'h0;
               s_nxt.rxShift = 9'h000;
               // a glitch shorter than half a bit is not a start
               s_nxt.rxPh = s_r.rxLevel ? PH_IDLE : PH_DATA;
            end
         end
         PH_DATA: begin
            if (s_r.rxCnt == {SPDR_PW{1'b0}}) begin
               s_nxt.rxCnt = periodLen - 23'h000001;
               s_nxt.rxShift = {s_r.rxLevel, s_r.rxShift[8:1]};
               s_nxt.rxBits = s_r.rxBits + 4'h1;
               if (s_r.rxBits + 4'h1 == rxLen) begin
                  s_nxt.rxPh = PH_STOP;
               end
            end
         end
         PH_STOP: begin
            if (s_r.rxCnt == {SPDR_PW{1'b0}}) begin
               rxPush = 1'b1;
               // eight-bit frames arrive in the upper bits
               if (s_r.rxSta[SPDR_RX_RX9]) begin
                  rxWord = {~s_r.rxLevel, s_r.rxShift};
               end else begin
                  rxWord = {~s_r.rxLevel, 1'b0, s_r.rxShift[8:1]};
               end
               s_nxt.rxPh = PH_IDLE;
            end
         end
         default: begin
            s_nxt.rxPh = PH_IDLE;
         end
      endcase

      // apb answer one cycle after the access phase begins
      // a fixed wait state keeps read data registered at the cost of one cycle
      s_nxt.pready = psel & penable & ~s_r.pready;
      s_nxt.pslverr = 1'b0;
      if (psel && penable && !s_r.pready) begin
         s_nxt.prdata = 32'h00000000;
         unique case (paddr)
            SPDR_ADDR_RXDATA: begin
               if (!pwrite) begin
                  s_nxt.prdata = {24'h000000, bufHead[7:0]};
               end
            end
            SPDR_ADDR_TXDATA: begin
               s_nxt.prdata = {24'h000000, s_r.txData};
            end
            SPDR_ADDR_DIVLO: begin
               s_nxt.prdata = {24'h000000, s_r.divLo};
            end
            SPDR_ADDR_DIVHI: begin
               s_nxt.prdata = {24'h000000, s_r.divHi};
            end
            SPDR_ADDR_RXSTA: begin
               s_nxt.prdata[7:0] = s_r.rxSta & SPDR_RX_WMASK;
               s_nxt.prdata[SPDR_RX_FERR] = bufHead[9];
               s_nxt.prdata[SPDR_RX_OERR] = s_r.oerr;
               s_nxt.prdata[SPDR_RX_NINTH] = bufHead[8];
            end
            SPDR_ADDR_TXSTA: begin
               s_nxt.prdata[7:0] = s_r.txSta & SPDR_TX_WMASK;
               s_nxt.prdata[SPDR_TX_TRMT] = (s_r.txPh == PH_IDLE);
            end
            SPDR_ADDR_RATE: begin
               s_nxt.prdata[7:0] = s_r.rateCtl & SPDR_RC_WMASK;
               s_nxt.prdata[SPDR_RC_IDLE] = (s_r.rxPh == PH_IDLE);
            end
            default: begin
               s_nxt.pslverr = 1'b1;
            end
         endcase
      end

      // register writes take effect on the completing edge
      if (access && pwrite) begin
         unique case (paddr)
            SPDR_ADDR_TXDATA: begin
               s_nxt.txData = pwdata[7:0];
               s_nxt.txFull = 1'b1;
            end
            SPDR_ADDR_DIVLO: begin
               s_nxt.divLo = pwdata[7:0];
               s_nxt.brgCnt = {SPDR_PW{1'b0}};
            end
            SPDR_ADDR_DIVHI: begin
               s_nxt.divHi = pwdata[7:0];
               s_nxt.brgCnt = {SPDR_PW{1'b0}};
            end
            SPDR_ADDR_RXSTA: begin
               s_nxt.rxSta = pwdata[7:0] & SPDR_RX_WMASK;
               // dropping continuous receive clears the overrun
               if (!pwdata[SPDR_RX_CREN]) begin
                  s_nxt.oerr = 1'b0;
               end
            end
            SPDR_ADDR_TXSTA: begin
               s_nxt.txSta = pwdata[7:0] & SPDR_TX_WMASK;
            end
            SPDR_ADDR_RATE: begin
               s_nxt.rateCtl = pwdata[7:0] & SPDR_RC_WMASK;
            end
            default: begin
            end
         endcase
      end

      // two-entry receive buffer
      bufPop = access && !pwrite && (paddr == SPDR_ADDR_RXDATA) && (s_r.bufCnt != 2'h0);
      bufPush = rxPush && (s_r.bufCnt != 2'h2 || bufPop);
      if (bufPush) begin
         s_nxt.bufMem[s_r.bufWr] = rxWord;
         s_nxt.bufWr = ~s_r.bufWr;
      end
      if (bufPop) begin
         s_nxt.bufRd = ~s_r.bufRd;
      end
      s_nxt.bufCnt = s_r.bufCnt + {1'b0, bufPush} - {1'b0, bufPop};
      // overrun set wins over a clear in the same cycle
      if (rxPush && !bufPush) begin
         s_nxt.oerr = 1'b1;
      end

      // port disabled: hold engines idle, line at rest
      if (!spen) begin
         s_nxt.txPh = PH_IDLE;
         s_nxt.rxPh = PH_IDLE;
         s_nxt.txPin = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s_r.txData <= SPDR_RST_BYTE;
         s_r.txFull <= 1'b0;
         s_r.divLo <= SPDR_RST_BYTE;
         s_r.divHi <= SPDR_RST_BYTE;
         s_r.rxSta <= SPDR_RST_BYTE;
         s_r.txSta <= SPDR_RST_BYTE;
         s_r.rateCtl <= SPDR_RST_BYTE;
         s_r.ferr <= 1'b0;
         s_r.oerr <= 1'b0;
         s_r.bufMem <= '0;
         s_r.bufWr <= 1'b0;
         s_r.bufRd <= 1'b0;
         s_r.bufCnt <= 2'h0;
         s_r.brgCnt <= '0;
         s_r.rxCnt <= '0;
         s_r.txPh <= PH_IDLE;
         s_r.rxPh <= PH_IDLE;
         s_r.txShift <= 9'h000;
         s_r.txBits <= 4'h0;
         s_r.rxShift <= 9'h000;
         s_r.rxBits <= 4'h0;
         s_r.pinSync <= 3'h7;
         s_r.rxLevel <= 1'b1;
         s_r.txPin <= 1'b1;
         s_r.prdata <= 32'h00000000;
         s_r.pready <= 1'b0;
         s_r.pslverr <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign txPin = s_r.txPin;
endmodule
`default_nettype wire

// ===== dv/spdr_core_sva.sv
// port assertions for the serial port core
`timescale 1ns/10ps
`default_nettype none
module spdr_core_sva (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // serial line
   input wire logic rxPin,
   input wire logic txPin
);
   import spdr_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////
   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("apb answer not after one wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held past one cycle");
   a_err_unmapped: assert property (pready && paddr > SPDR_ADDR_RATE |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_err_mapped: assert property (pready && paddr <= SPDR_ADDR_RATE && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped access refused");
   a_rx_upper: assert property (
      pready && !pwrite && paddr == SPDR_ADDR_RXDATA |-> prdata[31:8] == 24'h0)
      else $error("receive data upper bits not zero");
   // a restart delays the next tick by at least four clocks
   a_divlo_restart: assert property (
      pready && pwrite && paddr == SPDR_ADDR_DIVLO |=> ##1 $stable(txPin) [*2])
      else $error("line moved right after low divisor write");
   a_divhi_restart: assert property (
      pready && pwrite && paddr == SPDR_ADDR_DIVHI |=> ##1 $stable(txPin) [*2])
      else $error("line moved right after high divisor write");
   a_start_min: assert property ($fell(txPin) |-> !txPin [*4])
      else $error("start bit shorter than shortest period");
   a_reset_idle: assert property ($rose(nrst) |-> txPin && !pready)
      else $error("line or bus not idle after reset");
endmodule
bind spdr_core spdr_core_sva u_sva (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .rxPin(rxPin), .txPin(txPin));
`default_nettype wire

// ===== dv/spdr_remote.sv
// remote serial station: frame sender and frame sampler
`timescale 1ns/10ps
`default_nettype none
module spdr_remote (
   // clock
   input wire logic clk_sys,
   // serial line
   input wire logic txPin,
   output logic rxPin
);
   initial rxPin = 1'b1;
   ////////////////////////////////////////////////////////////
   // start low, data lsb first, stop as given, then idle high
   task automatic send(input logic [8:0] d, input int nb, input int per, input logic stp);
      logic [10:0] f;
      f = {1'b1, d, 1'b0};
      f[nb + 1] = stp;
      @(posedge clk_sys);
      for (int i = 0; i <= nb + 1; i++) begin
         rxPin <= f[i];
         repeat (per) @(posedge clk_sys);
      end
      // a low stop bit must not leave the line parked low
      rxPin <= 1'b1;
   endtask
   // period taken from the start bit, so data bit 0 must be one
   task automatic recv(input int nb, output logic [9:0] d, output int per);
      per = 0;
      d = 10'h000;
      @(posedge clk_sys iff txPin === 1'b0);
      do begin
         @(posedge clk_sys);
         per++;
      end while (txPin === 1'b0 && per < 5000);
      repeat (per / 2) @(posedge clk_sys);
      for (int i = 0; i <= nb; i++) begin
         d[i] = txPin;
         if (i < nb) repeat (per) @(posedge clk_sys);
      end
   endtask
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for the serial port core
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin cmpCount++; if ((g) !== (e)) begin errTotal++; \
   $display("mismatch %s exp %0h got %0h", n, e, g); end end
module testbench;
   import spdr_pkg::*;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic rxPin;
   logic txPin;
   logic [31:0] rd;
   logic er;
   int errTotal = 0;
   int cmpCount = 0;
   int cycles = 0;
   always #2 clk_sys = ~clk_sys;
   spdr_core u_dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rxPin(rxPin), .txPin(txPin));
   spdr_remote u_peer (.clk_sys(clk_sys), .txPin(txPin), .rxPin(rxPin));
   ////////////////////////////////////////////////////////////
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         n++;
      end
      `CHK("pready", 1'b1, pready)
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e, input string n);
      apb(a, 1'b0, 32'h0);
      `CHK(n, {24'h0, e}, rd)
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmpCount, errTotal);
      if (errTotal == 0 && cmpCount > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   task automatic test_regs();
      chk_rd(SPDR_ADDR_TXDATA, 8'h00, "txdata reset");
      chk_rd(SPDR_ADDR_DIVLO, 8'h00, "divlo reset");
      apb(SPDR_ADDR_DIVHI, 1'b1, 32'hA7);
      chk_rd(SPDR_ADDR_DIVHI, 8'hA7, "divhi");
      apb(SPDR_ADDR_RXDATA, 1'b1, 32'hAA);
      chk_rd(SPDR_ADDR_RXDATA, 8'h00, "rxdata read only");
      apb(8'h1C, 1'b0, 32'h0);
      `CHK("unmapped err", 1'b1, er)
      $display("test regs done");
   endtask
   task automatic test_rates();
      logic [9:0] d;
      logic [7:0] hi;
      logic sync;
      logic wide;
      logic fast;
      int k;
      int n;
      int per;
      apb(SPDR_ADDR_RXSTA, 1'b1, 32'h80);
      for (int m = 0; m < 6; m++) begin
         sync = m > 3;
         wide = m[0];
         fast = m == 2 || m == 3 || m == 5;
         k = sync ? 4 : (wide ? (fast ? 4 : 16) : (fast ? 16 : 64));
         // high byte kept zero where a wide divisor would make the run long
         hi = (k == 16 && wide) ? 8'h00 : 8'h01;
         n = wide ? int'({hi, 8'h02}) : 2;
         apb(SPDR_ADDR_RATE, 1'b1, {28'h0, wide, 3'h0});
         apb(SPDR_ADDR_TXSTA, 1'b1, {26'h0, 1'b1, sync, 1'b0, fast, 2'h0});
         apb(SPDR_ADDR_DIVLO, 1'b1, 32'h02);
         apb(SPDR_ADDR_DIVHI, 1'b1, {24'h0, hi});
         apb(SPDR_ADDR_TXDATA, 1'b1, 32'h55);
         u_peer.recv(8, d, per);
         `CHK("bit period", k * (n + 1), per)
         `CHK("tx frame", 10'h155, d)
         repeat (per) @(posedge clk_sys);
      end
      $display("test rates done");
   endtask
   task automatic test_rx();
      apb(SPDR_ADDR_RATE, 1'b1, 32'h0);
      apb(SPDR_ADDR_TXSTA, 1'b1, 32'h24);
      apb(SPDR_ADDR_DIVLO, 1'b1, 32'h02);
      apb(SPDR_ADDR_RXSTA, 1'b1, 32'hD0);
      // third frame lands on a full buffer
      u_peer.send(9'h1A5, 9, 48, 1'b1);
      u_peer.send(9'h03C, 9, 48, 1'b1);
      u_peer.send(9'h177, 9, 48, 1'b1);
      repeat (10) @(posedge clk_sys);
      chk_rd(SPDR_ADDR_RXSTA, 8'hD3, "rx status head");
      chk_rd(SPDR_ADDR_RXDATA, 8'hA5, "rx word0");
      chk_rd(SPDR_ADDR_RXSTA, 8'hD2, "rx status next");
      chk_rd(SPDR_ADDR_RXDATA, 8'h3C, "rx word1");
      chk_rd(SPDR_ADDR_TXSTA, 8'h26, "tx shifter idle");
      chk_rd(SPDR_ADDR_RATE, 8'h40, "rx idle");
      // dropping continuous receive clears the overrun; then an eight-bit frame with a low stop
      apb(SPDR_ADDR_RXSTA, 1'b1, 32'h80);
      apb(SPDR_ADDR_RXSTA, 1'b1, 32'h90);
      u_peer.send(9'h0C3, 8, 48, 1'b0);
      repeat (10) @(posedge clk_sys);
      chk_rd(SPDR_ADDR_RXSTA, 8'h94, "rx status eight");
      chk_rd(SPDR_ADDR_RXDATA, 8'hC3, "rx word eight");
      $display("test rx done");
   endtask
   task automatic test_txbuf();
      logic [9:0] d0;
      logic [9:0] d1;
      int p0;
      int p1;
      apb(SPDR_ADDR_TXDATA, 1'b1, 32'h33);
      fork
         begin
            u_peer.recv(8, d0, p0);
            u_peer.recv(8, d1, p1);
         end
         begin
            wait (txPin === 1'b0);
            apb(SPDR_ADDR_TXDATA, 1'b1, 32'hC9);
         end
      join
      `CHK("tx first", 10'h133, d0)
      `CHK("tx second", 10'h1C9, d1)
      // nine-bit frame, ninth bit set
      apb(SPDR_ADDR_TXSTA, 1'b1, 32'h65);
      apb(SPDR_ADDR_TXDATA, 1'b1, 32'h3B);
      u_peer.recv(9, d0, p0);
      `CHK("tx nine", 10'h33B, d0)
      `CHK("tx nine period", 48, p0)
      $display("test txbuf done");
   endtask
   ////////////////////////////////////////////////////////////
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         errTotal++;
         finish_test();
      end
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      nrst <= 1'b1;
      test_regs();
      test_rates();
      test_rx();
      test_txbuf();
      finish_test();
   end
endmodule
`default_nettype wire
